/* rtl/wnd_defs.svh */
// Offsets, field positions, reset values and timing counts of the node data map
// Function
// [RULE_01] A new node report overwrites that node's fast-read record.
// [RULE_02] A record is zeroed when no report arrives within its timeout.
// [RULE_03] Any write to record word 0 zeroes its measurement and age.
// [RULE_04] A record is seven words: age, four data, battery, signal strength.
// [RULE_05] Record of position n starts at raw register 1000 plus 7n.
// [RULE_06] Four coils per node at raw 2000 plus 4n; activity 0, exception 1.
// [RULE_07] Fifty registers per node at raw 2000 plus 50n; 5-15 give report data. The code maps report data to 5-11 only; 12-15 read 0.
// [RULE_08] Per-node offsets 19 to 23 are readable and writable settings.
// [RULE_09] Pending coil sets on a settings change, clears once the node accepts.
// [RULE_10] Master keeps exception period no larger than standard period.
// [RULE_11] Master keeps both periods divided by samples per report at least 1.
// [RULE_12] Alignment setting takes 0 to 5, defaults 0; 0 means free running.
// [RULE_13] Alignment 1 to 5 lands reports near multiples of the interval.
// [RULE_14] Alignment 1 to 5 adds 1, 3, 7, 15 or 30 random seconds spread.
// [RULE_15] Seconds count is 32 bits; high half first, low half write commits.
// [RULE_16] Writing true to the pending coil resends settings; false is ignored.
// [RULE_17] List positions 0 to 49 are valid in every per-node decode.
`ifndef WND_DEFS_SVH
`define WND_DEFS_SVH
`define NODES 50
`define REC_BASE 16'h03E8
`define REC_END 16'h0546
`define REC_WORDS 16'h0007
`define NREG_BASE 16'h07D0
`define NREG_END 16'h1194
`define NREG_WORDS 16'h0032
`define COIL_BASE 16'h07D0
`define COIL_END 16'h0898
`define GW_TIME_HI 16'h000A
`define GW_TIME_LO 16'h000B
`define OFF_BATT 6'h05
`define OFF_SIGNAL_STRENGTH 6'h06
`define OFF_STATUS 6'h07
`define OFF_DATA0 6'h08
`define OFF_TIMEOUT 6'h12
`define OFF_CFG_FIRST 6'h13
`define OFF_CFG_LAST 6'h17
`define OFF_SYNC 6'h2D
`define SYNC_MAX 3'h5
`define SYNC_RST 3'h0
`define TIMEOUT_RST 16'h0258
`define INTERVAL_RST 16'h0258
`define COIL_ACTIVE 2'h0
`define COIL_EXC 2'h1
`define COIL_PEND 2'h2
`define SECOND_NS 1000000000
`define CLK_PERIOD_NS 5
`define TICK_CYCLES (`SECOND_NS / `CLK_PERIOD_NS)
`endif

/* rtl/wnd_pkg.sv */
// Types shared by the node data map hub and its node slots
package wnd_pkg;
  typedef struct packed {
    logic exc;
    logic [15:0] status;
    logic [3:0][15:0] data;
    logic [15:0] batt;
    logic [15:0] signal_strength;
  } rpt_s;
endpackage

/* rtl/node_if.sv */
// Hub to node slot signal group
`timescale 1ns/10ps
interface node_if;
  import wnd_pkg::*;
  logic tick;
  logic realign;
  logic rpt_valid;
  rpt_s rpt;
  logic wr_rec;
  logic wr_nreg;
  logic coil_force;
  logic ack;
  logic [5:0] off;
  logic [15:0] wdata;
  logic [4:0] rnd;
  logic [15:0] rec_word;
  logic [15:0] nreg_word;
  logic active;
  logic exception;
  logic pending;
  logic due;
  logic sync_bad;
  modport hub(output tick, realign, rpt_valid, rpt, wr_rec, wr_nreg, coil_force, ack, off,
    wdata, rnd, input rec_word, nreg_word, active, exception, pending, due, sync_bad);
  modport node(input tick, realign, rpt_valid, rpt, wr_rec, wr_nreg, coil_force, ack, off,
    wdata, rnd, output rec_word, nreg_word, active, exception, pending, due, sync_bad);
endinterface

/* rtl/node_slot.sv */
// One node's record, settings, pending flag and report alignment
`timescale 1ns/10ps
`include "wnd_defs.svh"
module node_slot import wnd_pkg::*; (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst, // Async reset, high
  node_if.node nif // Hub side
);
  logic [15:0] age_q;
  rpt_s rec_q;
  logic active_q;
  logic [15:0] timeout_q;
  logic [4:0][15:0] cfg_q;
  logic [2:0] sync_q;
  logic pending_q;
  logic [15:0] phase_q;
  logic [4:0] jit_q;
  logic jit_run_q;
  logic due_q;
  logic clr0, cfg_wr, expire;
  logic [4:0] mask;

  assign clr0 = nif.wr_rec && nif.off == 6'h00;
  assign cfg_wr = nif.wr_nreg && (nif.off == `OFF_TIMEOUT || nif.off == `OFF_SYNC
    || (nif.off >= `OFF_CFG_FIRST && nif.off <= `OFF_CFG_LAST));
  assign expire = timeout_q != 16'h0000 && (age_q + 16'h0001) >= timeout_q;
  assign nif.sync_bad = nif.wr_nreg && nif.off == `OFF_SYNC && nif.wdata > 16'(`SYNC_MAX);

  // ==========================================
  // Fast-read record
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      age_q <= 16'h0000;
      rec_q <= '0;
      active_q <= 1'b0;
    end else if (nif.rpt_valid) begin
      age_q <= 16'h0000; // RULE_01
      rec_q <= nif.rpt; // RULE_01
      active_q <= 1'b1;
    end else if (clr0) begin
      age_q <= 16'h0000; // RULE_03
      rec_q.data <= '0; // RULE_03
    end else if (nif.tick) begin
      if (expire) begin
        age_q <= 16'h0000; // RULE_02
        rec_q <= '0; // RULE_02
        active_q <= 1'b0;
      end else if (age_q != 16'hFFFF) begin
        age_q <= age_q + 16'h0001;
      end
    end
  end

  // ==========================================
  // Settings and pending flag
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      timeout_q <= `TIMEOUT_RST;
      cfg_q <= {64'h0, `INTERVAL_RST};
      sync_q <= `SYNC_RST; // RULE_12
    end else if (nif.wr_nreg) begin
      if (nif.off == `OFF_TIMEOUT) begin
        timeout_q <= nif.wdata;
      end
      if (nif.off >= `OFF_CFG_FIRST && nif.off <= `OFF_CFG_LAST) begin
        cfg_q[3'(nif.off - `OFF_CFG_FIRST)] <= nif.wdata; // RULE_08
      end
      if (nif.off == `OFF_SYNC && !nif.sync_bad) begin
        sync_q <= nif.wdata[2:0]; // RULE_12
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pending_q <= 1'b0;
    end else if (cfg_wr || nif.coil_force) begin
      pending_q <= 1'b1; // RULE_09 RULE_16
    end else if (nif.ack) begin
      pending_q <= 1'b0; // RULE_09
    end
  end

  // ==========================================
  // Report alignment with random spread
  always_comb begin
    case (sync_q)
      3'h1: mask = 5'h01;
      3'h2: mask = 5'h03;
      3'h3: mask = 5'h07;
      3'h4: mask = 5'h0F;
      3'h5: mask = 5'h1E;
      default: mask = 5'h00;
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      phase_q <= 16'h0000;
      jit_q <= 5'h00;
      jit_run_q <= 1'b0;
      due_q <= 1'b0;
    end else begin
      due_q <= 1'b0;
      if (nif.realign || sync_q == 3'h0) begin
        phase_q <= 16'h0000;
        jit_run_q <= 1'b0;
      end else if (nif.tick) begin
        if (jit_run_q && jit_q == 5'h00) begin
          due_q <= 1'b1; // RULE_13
          jit_run_q <= 1'b0;
        end else if (jit_run_q) begin
          jit_q <= jit_q - 5'h01;
        end
        // Wrap comes last so a pulse on the same tick cannot cancel the new spread
        if (phase_q + 16'h0001 >= cfg_q[0]) begin
          phase_q <= 16'h0000; // RULE_13
          jit_q <= nif.rnd & mask; // RULE_14
          jit_run_q <= 1'b1;
        end else begin
          phase_q <= phase_q + 16'h0001;
        end
      end
    end
  end

  // ==========================================
  // Read words
  always_comb begin
    case (nif.off)
      6'h00: nif.rec_word = age_q; // RULE_04
      6'h01, 6'h02, 6'h03, 6'h04: nif.rec_word = rec_q.data[2'(nif.off - 6'h01)];
      6'h05: nif.rec_word = rec_q.batt;
      6'h06: nif.rec_word = rec_q.signal_strength;
      default: nif.rec_word = 16'h0000;
    endcase
  end

  always_comb begin
    nif.nreg_word = 16'h0000;
    if (nif.off == `OFF_BATT) nif.nreg_word = rec_q.batt; // RULE_07
    if (nif.off == `OFF_SIGNAL_STRENGTH) nif.nreg_word = rec_q.signal_strength;
    if (nif.off == `OFF_STATUS) nif.nreg_word = rec_q.status;
    if (nif.off >= `OFF_DATA0 && nif.off < `OFF_DATA0 + 6'h04) begin
      nif.nreg_word = rec_q.data[2'(nif.off - `OFF_DATA0)];
    end
    if (nif.off == `OFF_TIMEOUT) nif.nreg_word = timeout_q;
    if (nif.off >= `OFF_CFG_FIRST && nif.off <= `OFF_CFG_LAST) begin
      nif.nreg_word = cfg_q[3'(nif.off - `OFF_CFG_FIRST)]; // RULE_08
    end
    if (nif.off == `OFF_SYNC) nif.nreg_word = {13'h0000, sync_q};
  end

  assign nif.active = active_q;
  assign nif.exception = rec_q.exc;
  assign nif.pending = pending_q;
  assign nif.due = due_q;

  // ==========================================
  // Checks
  rpt_load_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_01
    nif.rpt_valid |=> age_q == 16'h0000 && rec_q == $past(nif.rpt) && active_q)
    else $error("report not loaded");
  rec_clear_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_03
    clr0 && !nif.rpt_valid |=> age_q == 16'h0000 && rec_q.data == '0)
    else $error("record clear failed");
  timeout_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_02
    nif.tick && !nif.rpt_valid && !clr0 && expire |=> rec_q == '0 && !active_q)
    else $error("record not aged out");
  pend_set_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_09
    cfg_wr || nif.coil_force |=> pending_q)
    else $error("pending not set");
  pend_clr_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_09
    nif.ack && !cfg_wr && !nif.coil_force |=> !pending_q)
    else $error("pending not cleared");
  sync_range_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_12
    sync_q <= `SYNC_MAX)
    else $error("alignment out of range");
  spread_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_14
    jit_run_q |-> jit_q <= mask)
    else $error("spread too large");
endmodule

/* rtl/wireless_node_data_map.sv */
// Node data map hub: register and coil decode, seconds count, node slots
`timescale 1ns/10ps
`include "wnd_defs.svh"
module wireless_node_data_map import wnd_pkg::*; #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES // Cycles per gateway second
) (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst, // Async reset, high
  input wire logic i_reg_rd, // Register read strobe
  input wire logic i_reg_wr, // Register write strobe
  input wire logic [15:0] i_reg_addr, // Raw register address
  input wire logic [15:0] i_reg_wdata, // Register write data
  output logic [15:0] o_reg_rdata, // Register read data
  output logic o_reg_ack, // Register access done
  output logic o_reg_err, // Register access refused
  input wire logic i_coil_rd, // Coil read strobe
  input wire logic i_coil_wr, // Coil write strobe
  input wire logic [15:0] i_coil_addr, // Raw coil address
  input wire logic i_coil_wdata, // Coil write value
  output logic o_coil_rdata, // Coil read value
  output logic o_coil_ack, // Coil access done
  output logic o_coil_err, // Coil access refused
  input wire logic i_rpt_valid, // Node report strobe
  input wire logic [5:0] i_rpt_slot, // Reporting list position
  input wire rpt_s i_rpt, // Reported values
  input wire logic i_cfg_ack, // Node accepted settings
  input wire logic [5:0] i_cfg_ack_slot, // Accepting list position
  output logic [`NODES-1:0] o_cfg_pending, // Settings to send, per node
  output logic [`NODES-1:0] o_sync_due, // Aligned report prompt, per node
  output logic [31:0] o_seconds // Gateway seconds count
);
  logic [15:0] frel, wrel, crel;
  logic [5:0] fslot, wslot, cslot, foff, woff;
  logic [1:0] coff;
  logic rec_hit, nreg_hit, hi_hit, lo_hit, coil_hit;
  logic [15:0] rec_w [`NODES];
  logic [15:0] nreg_w [`NODES];
  logic [`NODES-1:0] act, exc, bad;
  logic [31:0] sec_q;
  logic [15:0] hi_shadow_q;
  logic [31:0] tick_cnt_q;
  logic tick, commit;
  logic [15:0] lfsr_q;
  logic [15:0] reg_rdata_q;
  logic reg_ack_q, reg_err_q;
  logic coil_rdata_q, coil_ack_q, coil_err_q;

  // ==========================================
  // Address decode
  always_comb begin
    frel = i_reg_addr - `REC_BASE;
    wrel = i_reg_addr - `NREG_BASE;
    crel = i_coil_addr - `COIL_BASE;
    fslot = 6'(frel / `REC_WORDS); // RULE_05
    foff = 6'(frel - 16'(fslot) * `REC_WORDS); // RULE_04
    wslot = 6'(wrel / `NREG_WORDS); // RULE_07
    woff = 6'(wrel - 16'(wslot) * `NREG_WORDS);
    cslot = crel[7:2]; // RULE_06
    coff = crel[1:0];
  end

  // Range checks limit every slot to 0..49
  assign rec_hit = i_reg_addr >= `REC_BASE && i_reg_addr < `REC_END; // RULE_17
  assign nreg_hit = i_reg_addr >= `NREG_BASE && i_reg_addr < `NREG_END; // RULE_17
  assign coil_hit = i_coil_addr >= `COIL_BASE && i_coil_addr < `COIL_END; // RULE_17
  assign hi_hit = i_reg_addr == `GW_TIME_HI;
  assign lo_hit = i_reg_addr == `GW_TIME_LO;

  // ==========================================
  // Gateway seconds count
  assign tick = tick_cnt_q == TICK_CYCLES - 1;
  assign commit = i_reg_wr && lo_hit;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (commit || tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      hi_shadow_q <= 16'h0000;
    end else if (i_reg_wr && hi_hit) begin
      hi_shadow_q <= i_reg_wdata; // RULE_15
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      sec_q <= 32'h0000_0000;
    end else if (commit) begin
      sec_q <= {hi_shadow_q, i_reg_wdata}; // RULE_15
    end else if (tick) begin
      sec_q <= sec_q + 32'h0000_0001;
    end
  end

  assign o_seconds = sec_q;

  // ==========================================
  // Random source for report spread
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      lfsr_q <= 16'hACE1;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    end
  end

  // ==========================================
  // Node slots
  node_if nif [`NODES] ();

  genvar g;
  for (g = 0; g < `NODES; g++) begin : g_node
    assign nif[g].tick = tick;
    assign nif[g].realign = commit; // RULE_13
    assign nif[g].rpt_valid = i_rpt_valid && i_rpt_slot == 6'(g); // RULE_01
    assign nif[g].rpt = i_rpt;
    assign nif[g].wr_rec = i_reg_wr && rec_hit && fslot == 6'(g); // RULE_03
    assign nif[g].wr_nreg = i_reg_wr && nreg_hit && wslot == 6'(g); // RULE_08
    assign nif[g].coil_force = i_coil_wr && coil_hit && cslot == 6'(g)
      && coff == `COIL_PEND && i_coil_wdata; // RULE_16
    assign nif[g].ack = i_cfg_ack && i_cfg_ack_slot == 6'(g);
    assign nif[g].off = rec_hit ? foff : woff;
    assign nif[g].wdata = i_reg_wdata;
    assign nif[g].rnd = 5'({lfsr_q, lfsr_q} >> (g % 11));
    assign rec_w[g] = nif[g].rec_word;
    assign nreg_w[g] = nif[g].nreg_word;
    assign act[g] = nif[g].active;
    assign exc[g] = nif[g].exception;
    assign bad[g] = nif[g].sync_bad;
    assign o_cfg_pending[g] = nif[g].pending;
    assign o_sync_due[g] = nif[g].due;
    node_slot u_node (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .nif(nif[g])
    );
  end

  // ==========================================
  // Register answers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      reg_ack_q <= 1'b0;
      reg_err_q <= 1'b0;
      reg_rdata_q <= 16'h0000;
    end else begin
      reg_ack_q <= i_reg_rd || i_reg_wr;
      reg_err_q <= (i_reg_rd || i_reg_wr) && !(rec_hit || nreg_hit || hi_hit || lo_hit)
        || (i_reg_wr && nreg_hit && bad[wslot]);
      if (i_reg_rd) begin
        if (rec_hit) begin
          reg_rdata_q <= rec_w[fslot]; // RULE_05
        end else if (nreg_hit) begin
          reg_rdata_q <= nreg_w[wslot]; // RULE_07
        end else if (hi_hit) begin
          reg_rdata_q <= sec_q[31:16];
        end else if (lo_hit) begin
          reg_rdata_q <= sec_q[15:0];
        end else begin
          reg_rdata_q <= 16'h0000;
        end
      end
    end
  end

  assign o_reg_rdata = reg_rdata_q;
  assign o_reg_ack = reg_ack_q;
  assign o_reg_err = reg_err_q;

  // ==========================================
  // Coil answers
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      coil_ack_q <= 1'b0;
      coil_err_q <= 1'b0;
      coil_rdata_q <= 1'b0;
    end else begin
      coil_ack_q <= i_coil_rd || i_coil_wr;
      coil_err_q <= (i_coil_rd || i_coil_wr) && !coil_hit;
      if (i_coil_rd) begin
        coil_rdata_q <= 1'b0;
        if (coil_hit) begin
          case (coff)
            `COIL_ACTIVE: coil_rdata_q <= act[cslot]; // RULE_06
            `COIL_EXC: coil_rdata_q <= exc[cslot]; // RULE_06
            `COIL_PEND: coil_rdata_q <= o_cfg_pending[cslot]; // RULE_09
            default: coil_rdata_q <= 1'b0;
          endcase
        end
      end
    end
  end

  assign o_coil_rdata = coil_rdata_q;
  assign o_coil_ack = coil_ack_q;
  assign o_coil_err = coil_err_q;

  // ==========================================
  // Checks
  sec_commit_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_15
    commit |=> sec_q == {$past(hi_shadow_q), $past(i_reg_wdata)})
    else $error("seconds commit wrong");
  sec_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_15
    i_reg_wr && hi_hit && !tick |=> sec_q == $past(sec_q))
    else $error("high half changed count");
  sec_step_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_15
    tick && !commit |=> sec_q == $past(sec_q) + 32'h0000_0001)
    else $error("seconds did not step");
  rec_read_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_05
    i_reg_rd && rec_hit |=> o_reg_ack && !o_reg_err && o_reg_rdata == $past(rec_w[fslot]))
    else $error("record read wrong");
  unmapped_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_17
    i_reg_rd && i_reg_addr >= `REC_END && i_reg_addr < `NREG_BASE |=> o_reg_err)
    else $error("unmapped not refused");
  coil_read_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_06
    i_coil_rd && coil_hit && coff == `COIL_ACTIVE |=> o_coil_rdata == $past(act[cslot]))
    else $error("activity coil wrong");
  pend_coil_a: assert property (@(posedge i_sys_clk) disable iff (i_rst) // RULE_16
    i_coil_wr && coil_hit && coff == `COIL_PEND && i_coil_wdata |=> o_cfg_pending[$past(cslot)])
    else $error("force resend lost");

  rpt_c: cover property (@(posedge i_sys_clk) i_rpt_valid ##[1:20] i_reg_rd && rec_hit);
  commit_c: cover property (@(posedge i_sys_clk) i_reg_wr && hi_hit ##[1:10] commit);
  pend_c: cover property (@(posedge i_sys_clk) |o_cfg_pending ##[1:50] i_cfg_ack);
  due_c: cover property (@(posedge i_sys_clk) |o_sync_due);
endmodule

/* sim/bus_master_model.sv */
// Register and coil master plus wireless node stand-in for the data map
`timescale 1ns/10ps
`include "wnd_defs.svh"
module bus_master_model import wnd_pkg::*; (
  input wire logic i_clk, // Clock
  output logic o_reg_rd, // Reg read
  output logic o_reg_wr, // Reg write
  output logic [15:0] o_reg_addr, // Reg address
  output logic [15:0] o_reg_wdata, // Reg data
  input wire logic [15:0] i_reg_rdata, // Reg read data
  input wire logic i_reg_ack, // Reg done
  input wire logic i_reg_err, // Reg refused
  output logic o_coil_rd, // Coil read
  output logic o_coil_wr, // Coil write
  output logic [15:0] o_coil_addr, // Coil address
  output logic o_coil_wdata, // Coil value
  input wire logic i_coil_rdata, // Coil read value
  input wire logic i_coil_ack, // Coil done
  input wire logic i_coil_err, // Coil refused
  output logic o_rpt_valid, // Report strobe
  output logic [5:0] o_rpt_slot, // Report slot
  output rpt_s o_rpt, // Report values
  output logic o_cfg_ack, // Settings accepted
  output logic [5:0] o_cfg_ack_slot // Accepting slot
);
  initial begin
    {o_reg_rd, o_reg_wr, o_coil_rd, o_coil_wr, o_rpt_valid, o_cfg_ack} = '0;
    {o_reg_addr, o_reg_wdata, o_coil_addr, o_coil_wdata, o_rpt_slot, o_cfg_ack_slot} = '0;
    o_rpt = '0;
  end
  // ==========================================
  // Bus cycles
  task automatic acc(input bit coil, input bit wr, input logic [15:0] a,
      input logic [15:0] d, output logic [15:0] q, output logic e);
    int i;
    @(negedge i_clk);
    o_reg_addr = a;
    o_coil_addr = a;
    o_reg_wdata = d;
    o_coil_wdata = d[0];
    o_reg_rd = !coil && !wr;
    o_reg_wr = !coil && wr;
    o_coil_rd = coil && !wr;
    o_coil_wr = coil && wr;
    @(negedge i_clk);
    {o_reg_rd, o_reg_wr, o_coil_rd, o_coil_wr} = '0;
    i = 0;
    while (((coil ? i_coil_ack : i_reg_ack) !== 1'b1) && i < 4) begin
      @(negedge i_clk);
      i++;
    end
    q = coil ? {15'h0000, i_coil_rdata} : i_reg_rdata;
    e = (i < 4) ? (coil ? i_coil_err : i_reg_err) : 1'bx;
  endtask
  task automatic set_seconds(input logic [31:0] v);
    logic [15:0] q;
    logic e;
    acc(1'b0, 1'b1, `GW_TIME_HI, v[31:16], q, e);
    acc(1'b0, 1'b1, `GW_TIME_LO, v[15:0], q, e);
  endtask
  // ==========================================
  // Node side
  task automatic report(input logic [5:0] s, input rpt_s r);
    @(negedge i_clk);
    o_rpt_valid = 1'b1;
    o_rpt_slot = s;
    o_rpt = r;
    @(negedge i_clk);
    o_rpt_valid = 1'b0;
    o_rpt = ~r;
  endtask
  task automatic accept(input logic [5:0] s);
    @(negedge i_clk);
    o_cfg_ack = 1'b1;
    o_cfg_ack_slot = s;
    @(negedge i_clk);
    o_cfg_ack = 1'b0;
    o_cfg_ack_slot = ~s;
  endtask
endmodule

/* sim/tb_top.sv */
// Self-checking bench for the node data map
`timescale 1ns/10ps
`include "wnd_defs.svh"
module tb_top import wnd_pkg::*; ;
  localparam int TK = 200;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic reg_rd, reg_wr, reg_ack, reg_err, coil_rd, coil_wr, coil_wdata, coil_rdata;
  logic coil_ack, coil_err, rpt_valid, cfg_ack;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, coil_addr;
  logic [5:0] rpt_slot, cfg_ack_slot;
  logic [`NODES-1:0] cfg_pending, sync_due;
  logic [31:0] seconds;
  rpt_s rpt;
  int n_errors = 0;
  int tests_run = 0;
  always #2.5 i_sys_clk = ~i_sys_clk;
  wireless_node_data_map #(.TICK_CYCLES(TK)) u_wireless_node_data_map (.i_sys_clk(i_sys_clk),
    .i_rst(i_rst), .i_reg_rd(reg_rd), .i_reg_wr(reg_wr), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata), .o_reg_ack(reg_ack), .o_reg_err(reg_err),
    .i_coil_rd(coil_rd), .i_coil_wr(coil_wr), .i_coil_addr(coil_addr),
    .i_coil_wdata(coil_wdata), .o_coil_rdata(coil_rdata), .o_coil_ack(coil_ack),
    .o_coil_err(coil_err), .i_rpt_valid(rpt_valid), .i_rpt_slot(rpt_slot), .i_rpt(rpt),
    .i_cfg_ack(cfg_ack), .i_cfg_ack_slot(cfg_ack_slot), .o_cfg_pending(cfg_pending),
    .o_sync_due(sync_due), .o_seconds(seconds));
  bus_master_model u_bus_master_model (.i_clk(i_sys_clk), .o_reg_rd(reg_rd),
    .o_reg_wr(reg_wr), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
    .i_reg_rdata(reg_rdata), .i_reg_ack(reg_ack), .i_reg_err(reg_err), .o_coil_rd(coil_rd),
    .o_coil_wr(coil_wr), .o_coil_addr(coil_addr), .o_coil_wdata(coil_wdata),
    .i_coil_rdata(coil_rdata), .i_coil_ack(coil_ack), .i_coil_err(coil_err),
    .o_rpt_valid(rpt_valid), .o_rpt_slot(rpt_slot), .o_rpt(rpt), .o_cfg_ack(cfg_ack),
    .o_cfg_ack_slot(cfg_ack_slot));
  // ==========================================
  // Helpers
  function automatic logic [15:0] fa(int s, int w);
    return 16'(`REC_BASE + 7 * s + w);
  endfunction
  function automatic logic [15:0] ra(int s, int o);
    return 16'(`NREG_BASE + 50 * s + o);
  endfunction
  function automatic logic [15:0] ca(int s, int o);
    return 16'(`COIL_BASE + 4 * s + o);
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input bit coil, input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] q;
    logic e;
    u_bus_master_model.acc(coil, 1'b0, a, 16'h0000, q, e);
    check(q, exp);
  endtask
  task automatic wr(input bit coil, input logic [15:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic e;
    u_bus_master_model.acc(coil, 1'b1, a, d, q, e);
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    rd(0, fa(0, 0), 16'h0000);
    rd(0, ra(3, 18), 16'h0258);
    rd(0, ra(3, 19), 16'h0258);
    rd(0, ra(3, 45), 16'h0000);
    check(|cfg_pending, 0);
    $display("test reset done");
  endtask
  task automatic t_report();
    rpt_s r;
    logic [15:0] q;
    logic e;
    r = {1'b1, 16'h00A5, 16'h4444, 16'h3333, 16'h2222, 16'h1111, 16'h0BA7, 16'h00C1};
    u_bus_master_model.report(6'd49, r);
    for (int w = 0; w < 4; w++) begin
      rd(0, fa(49, w + 1), r.data[w]);
      rd(0, ra(49, 8 + w), r.data[w]);
    end
    rd(0, fa(49, 5), r.batt);
    rd(0, fa(49, 6), r.signal_strength);
    rd(0, ra(49, 5), r.batt);
    rd(0, ra(49, 6), r.signal_strength);
    rd(0, ra(49, 7), r.status);
    rd(1, ca(49, 0), 16'h0001);
    rd(1, ca(49, 1), 16'h0001);
    wr(0, fa(49, 2), 16'hFFFF);
    rd(0, fa(49, 2), 16'h2222);
    repeat (3 * TK) @(negedge i_sys_clk);
    u_bus_master_model.acc(0, 0, fa(49, 0), 16'h0000, q, e);
    check(q > 16'h0002, 1);
    wr(0, fa(49, 0), 16'h1234);
    rd(0, fa(49, 1), 16'h0000);
    rd(0, fa(49, 5), r.batt);
    u_bus_master_model.acc(0, 0, fa(49, 0), 16'h0000, q, e);
    check(q > 16'h0001, 0);
    $display("test report done");
  endtask
  task automatic t_timeout();
    wr(0, ra(2, 18), 16'h0003);
    repeat (2) @(negedge i_sys_clk);
    check(cfg_pending[2], 1);
    u_bus_master_model.accept(6'd2);
    @(negedge i_sys_clk);
    check(cfg_pending[2], 0);
    u_bus_master_model.report(6'd2, '1);
    rd(1, ca(2, 0), 16'h0001);
    repeat (4 * TK + 10) @(negedge i_sys_clk);
    rd(0, fa(2, 1), 16'h0000);
    rd(0, fa(2, 5), 16'h0000);
    rd(1, ca(2, 0), 16'h0000);
    $display("test timeout done");
  endtask
  task automatic t_coil();
    wr(1, ca(7, 2), 16'h0000);
    repeat (2) @(negedge i_sys_clk);
    check(cfg_pending[7], 0);
    wr(1, ca(7, 2), 16'h0001);
    repeat (2) @(negedge i_sys_clk);
    check(cfg_pending[7], 1);
    rd(1, ca(7, 2), 16'h0001);
    wr(0, ra(7, 21), 16'h00AB);
    rd(0, ra(7, 21), 16'h00AB);
    u_bus_master_model.accept(6'd7);
    @(negedge i_sys_clk);
    check(cfg_pending[7], 0);
    $display("test coil done");
  endtask
  task automatic t_align();
    logic [15:0] q;
    logic e;
    int n5;
    int n6;
    for (int v = 1; v <= 5; v++) begin
      wr(0, ra(5, 45), 16'(v));
      rd(0, ra(5, 45), 16'(v));
    end
    u_bus_master_model.acc(0, 1, ra(5, 45), 16'h0006, q, e);
    check(e, 1);
    rd(0, ra(5, 45), 16'h0005);
    wr(0, ra(5, 45), 16'h0001);
    wr(0, ra(5, 19), 16'h0002);
    u_bus_master_model.set_seconds(32'h0001_0002);
    check(seconds, 32'h0001_0002);
    rd(0, `GW_TIME_HI, 16'h0001);
    n5 = 0;
    n6 = 0;
    repeat (10 * TK) begin
      @(negedge i_sys_clk);
      n5 += int'(sync_due[5]);
      n6 += int'(sync_due[6]);
    end
    check(n5 >= 4 && n5 <= 6, 1);
    check(n6, 0);
    $display("test align done");
  endtask
  task automatic t_unmapped();
    logic [15:0] q;
    logic e;
    u_bus_master_model.acc(0, 0, 16'h5000, 16'h0000, q, e);
    check(e, 1);
    u_bus_master_model.acc(0, 0, 16'h0600, 16'h0000, q, e);
    check(e, 1);
    u_bus_master_model.acc(1, 0, 16'h0898, 16'h0000, q, e);
    check(e, 1);
    $display("test unmapped done");
  endtask
  // ==========================================
  // Run control
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #250000;
    n_errors++;
    stop_test();
  end
  initial begin
    repeat (16) @(negedge i_sys_clk);
    i_rst = 1'b0;
    t_reset();
    t_report();
    t_timeout();
    t_coil();
    t_align();
    t_unmapped();
    stop_test();
  end
endmodule
